// file: src/dacci_channel.sv
`timescale 1ns/10ps
`include "dacci_defines.svh"

// One converter channel: control bits, held code and the code applied to the converter
module dacci_channel
(
    // Clock and reset
    input  wire logic                      ref_clk,
    input  wire logic                      nrst,
    // Register writes
    input  wire logic                      ctrl_we,
    input  wire logic                      code_we,
    input  wire logic [31:0]               wdata,
    // Update ticks
    input  wire logic                      timer_tick,
    // State
    output logic [`DACCI_CTRL_W-1:0]       ctrl,
    output logic [`DACCI_CODE_W-1:0]       code,
    output logic [`DACCI_CODE_W-1:0]       applied,
    output logic                           pending
);
    typedef struct packed {
        logic [`DACCI_CTRL_W-1:0] ctrl;
        logic [`DACCI_CODE_W-1:0] code;
        logic [`DACCI_CODE_W-1:0] applied;
        logic                     pending;
    } dacci_ch_state_t;

    dacci_ch_state_t state_reg;
    dacci_ch_state_t state_next;
    logic            tick;

    always_comb
    begin
        state_next = state_reg;
        tick = state_reg.ctrl[`DACCI_BIT_SRC] ? timer_tick : 1'b1;
        if (ctrl_we)
        begin
            state_next.ctrl = wdata[`DACCI_CTRL_W-1:0] & `DACCI_CTRL_MASK;
        end
        if (code_we)
        begin
            state_next.code = wdata[`DACCI_CODE_HI:`DACCI_CODE_LO];
            state_next.pending = 1'b1;
        end
        else if (state_reg.pending && tick)
        begin
            state_next.applied = state_reg.code;
            state_next.pending = 1'b0;
        end
        if (!state_next.ctrl[`DACCI_BIT_CLR_N])
        begin
            state_next.code = `DACCI_CODE_RESET;
            state_next.applied = `DACCI_CODE_RESET;
            state_next.pending = 1'b0;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
        begin
            state_reg.ctrl <= `DACCI_CTRL_RESET;
            state_reg.code <= `DACCI_CODE_RESET;
            state_reg.applied <= `DACCI_CODE_RESET;
            state_reg.pending <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign ctrl = state_reg.ctrl;
    assign code = state_reg.code;
    assign applied = state_reg.applied;
    assign pending = state_reg.pending;
endmodule : dacci_channel

// file: src/dacci_defines.svh
`ifndef DACCI_DEFINES_SVH
`define DACCI_DEFINES_SVH

// Register map: channel n control at 2n, code at 2n+1 (byte address = index * 4)
`define DACCI_CTRL_IDX(n)      (2 * (n))
`define DACCI_CODE_IDX(n)      (2 * (n) + 1)
`define DACCI_ADDR_W           8
`define DACCI_REG_BYTES        4
`define DACCI_CHANNELS         4
`define DACCI_CTRL_W           8
`define DACCI_CODE_W           12

// Control fields
`define DACCI_BIT_BYPASS       6
`define DACCI_BIT_SRC          5
`define DACCI_BIT_CLR_N        4
`define DACCI_RSV_HI           3
`define DACCI_RSV_LO           2
`define DACCI_RANGE_HI         1
`define DACCI_RANGE_LO         0
`define DACCI_CTRL_MASK        8'h73
`define DACCI_CTRL_RESET       8'h00

// Code register field
`define DACCI_CODE_HI          23
`define DACCI_CODE_LO          12
`define DACCI_CODE_RESET       12'h000

`endif

// file: src/dacci_pkg.sv
package dacci_pkg;
    typedef enum logic [1:0] {
        DACCI_RANGE_OFF,
        DACCI_RANGE_EXT,
        DACCI_RANGE_INT,
        DACCI_RANGE_SUPPLY
    } dacci_range_t;
endpackage : dacci_pkg

// file: src/dacci_top.sv
`timescale 1ns/10ps
`include "dacci_defines.svh"

module dacci_top
(
    // Clock and reset
    input  wire logic                                   ref_clk,
    input  wire logic                                   nrst,
    // Register port
    input  wire logic [`DACCI_ADDR_W-1:0]               addr,
    input  wire logic [31:0]                            wdata,
    input  wire logic                                   wr,
    input  wire logic                                   rd,
    output logic [31:0]                                 rdata,
    // Update tick from the first general timer, same clock domain
    input  wire logic                                   first_general_timer,
    // Converter controls
    output logic [`DACCI_CHANNELS*`DACCI_CODE_W-1:0]    conv_code,
    output logic [`DACCI_CHANNELS-1:0]                  buffer_bypass,
    output logic [`DACCI_CHANNELS-1:0]                  chan_powered,
    output logic [`DACCI_CHANNELS-1:0]                  out_drive_en,
    output logic [`DACCI_CHANNELS*2-1:0]                range_sel
);
    typedef struct packed {
        logic [31:0]                                rdata;
        logic [`DACCI_CHANNELS*`DACCI_CODE_W-1:0]   conv_code;
        logic [`DACCI_CHANNELS-1:0]                 bypass;
        logic [`DACCI_CHANNELS-1:0]                 powered;
        logic [`DACCI_CHANNELS*2-1:0]               range;
    } dacci_top_state_t;

    dacci_top_state_t state_reg;
    dacci_top_state_t state_next;

    logic [`DACCI_CTRL_W-1:0] ch_ctrl    [`DACCI_CHANNELS];
    logic [`DACCI_CODE_W-1:0] ch_code    [`DACCI_CHANNELS];
    logic [`DACCI_CODE_W-1:0] ch_applied [`DACCI_CHANNELS];
    logic [`DACCI_CHANNELS-1:0] ch_pending;
    logic [`DACCI_CHANNELS-1:0] ctrl_we;
    logic [`DACCI_CHANNELS-1:0] code_we;

    function automatic logic hit(input logic [`DACCI_ADDR_W-1:0] a, input int idx);
        hit = (a == `DACCI_ADDR_W'(idx * `DACCI_REG_BYTES));
    endfunction : hit

    genvar g;
    generate
        for (g = 0; g < `DACCI_CHANNELS; g++)
        begin : gen_ch
            assign ctrl_we[g] = wr && hit(addr, `DACCI_CTRL_IDX(g));
            assign code_we[g] = wr && hit(addr, `DACCI_CODE_IDX(g));
            dacci_channel u_ch
            (
                .ref_clk    (ref_clk),
                .nrst       (nrst),
                .ctrl_we    (ctrl_we[g]),
                .code_we    (code_we[g]),
                .wdata      (wdata),
                .timer_tick (first_general_timer),
                .ctrl       (ch_ctrl[g]),
                .code       (ch_code[g]),
                .applied    (ch_applied[g]),
                .pending    (ch_pending[g])
            );
        end
    endgenerate

    always_comb
    begin
        state_next = state_reg;
        state_next.rdata = 32'h0000_0000;
        for (int i = 0; i < `DACCI_CHANNELS; i++)
        begin
            // Read data reflect the values stored after any clear
            if (rd && hit(addr, `DACCI_CTRL_IDX(i)))
            begin
                state_next.rdata = {24'h00_0000, ch_ctrl[i]};
            end
            if (rd && hit(addr, `DACCI_CODE_IDX(i)))
            begin
                state_next.rdata = {8'h00, ch_code[i], 12'h000};
            end
            state_next.conv_code[i*`DACCI_CODE_W +: `DACCI_CODE_W] = ch_applied[i];
            state_next.bypass[i] = ch_ctrl[i][`DACCI_BIT_BYPASS];
            state_next.range[i*2 +: 2] = ch_ctrl[i][`DACCI_RANGE_HI:`DACCI_RANGE_LO];
            state_next.powered[i] = ch_ctrl[i][`DACCI_RANGE_HI:`DACCI_RANGE_LO]
                                    != dacci_pkg::DACCI_RANGE_OFF;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
        begin
            state_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign rdata = state_reg.rdata;
    assign conv_code = state_reg.conv_code;
    assign buffer_bypass = state_reg.bypass;
    assign chan_powered = state_reg.powered;
    // Output stage driven only while powered; otherwise high impedance
    assign out_drive_en = state_reg.powered;
    assign range_sel = state_reg.range;

    property p_bypass;
        @(posedge ref_clk) disable iff (!nrst)
        (wr && addr == `DACCI_ADDR_W'(`DACCI_CTRL_IDX(0) * 4))
        |-> ##2 buffer_bypass[0] == $past(wdata[`DACCI_BIT_BYPASS], 2);
    endproperty
    a_bypass: assert property (p_bypass) else $error("bypass not following control");

    property p_off;
        @(posedge ref_clk) disable iff (!nrst)
        (ch_ctrl[0][1:0] == 2'h0) |=> !out_drive_en[0];
    endproperty
    a_off: assert property (p_off) else $error("powered-down channel still drives");

    property p_clear;
        @(posedge ref_clk) disable iff (!nrst)
        !ch_ctrl[1][`DACCI_BIT_CLR_N] |-> ch_code[1] == 12'h000;
    endproperty
    a_clear: assert property (p_clear) else $error("clear did not zero code");

    property p_timer_wait;
        @(posedge ref_clk) disable iff (!nrst)
        (ch_pending[0] && ch_ctrl[0][`DACCI_BIT_SRC] && !first_general_timer && !code_we[0]
         && ch_ctrl[0][`DACCI_BIT_CLR_N] && !ctrl_we[0]) |=> $stable(ch_applied[0]);
    endproperty
    a_timer_wait: assert property (p_timer_wait) else $error("applied without tick");

    property p_core_update;
        @(posedge ref_clk) disable iff (!nrst)
        (code_we[0] && !ch_ctrl[0][`DACCI_BIT_SRC] && ch_ctrl[0][`DACCI_BIT_CLR_N]
         && !ctrl_we[0]) ##1 (!code_we[0] && !ctrl_we[0])
        |=> ch_applied[0] == $past(wdata[`DACCI_CODE_HI:`DACCI_CODE_LO], 2);
    endproperty
    a_core_update: assert property (p_core_update) else $error("core update late");

    property p_code_read;
        @(posedge ref_clk) disable iff (!nrst)
        (rd && addr == `DACCI_ADDR_W'(`DACCI_CODE_IDX(2) * 4))
        |=> rdata[11:0] == 12'h000 && rdata[31:24] == 8'h00;
    endproperty
    a_code_read: assert property (p_code_read) else $error("code read reserved set");

    property p_indep;
        @(posedge ref_clk) disable iff (!nrst)
        ctrl_we[0] |=> $stable(ch_ctrl[1]);
    endproperty
    a_indep: assert property (p_indep) else $error("channel control not independent");

    property p_conv;
        @(posedge ref_clk) disable iff (!nrst)
        1'b1 |=> conv_code[`DACCI_CODE_W-1:0] == $past(ch_applied[0]);
    endproperty
    a_conv: assert property (p_conv) else $error("converter code mismatch");

    property p_rd_idle;
        @(posedge ref_clk) disable iff (!nrst)
        !rd
        |=> rdata == 32'h0000_0000;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("idle read data not zero");

    property p_ctrl_rd;
        @(posedge ref_clk) disable iff (!nrst)
        (rd && hit(addr, `DACCI_CTRL_IDX(1)))
        |=> rdata == {24'h00_0000, $past(ch_ctrl[1])};
    endproperty
    a_ctrl_rd: assert property (p_ctrl_rd) else $error("control read wrong");

    property p_code_rd;
        @(posedge ref_clk) disable iff (!nrst)
        (rd && hit(addr, `DACCI_CODE_IDX(3)))
        |=> rdata[`DACCI_CODE_HI:`DACCI_CODE_LO] == $past(ch_code[3]);
    endproperty
    a_code_rd: assert property (p_code_rd) else $error("code read wrong");

    property p_ctrl_rsv;
        @(posedge ref_clk) disable iff (!nrst)
        (ch_ctrl[2] & ~(`DACCI_CTRL_MASK)) == 8'h00;
    endproperty
    a_ctrl_rsv: assert property (p_ctrl_rsv) else $error("reserved bit stored");

    property p_range_out;
        @(posedge ref_clk) disable iff (!nrst)
        1'b1
        |=> range_sel[3:2] == $past(ch_ctrl[1][`DACCI_RANGE_HI:`DACCI_RANGE_LO]);
    endproperty
    a_range_out: assert property (p_range_out) else $error("range output wrong");

    property p_pwr_out;
        @(posedge ref_clk) disable iff (!nrst)
        1'b1
        |=> chan_powered[2] == ($past(ch_ctrl[2][`DACCI_RANGE_HI:`DACCI_RANGE_LO]) != 2'h0);
    endproperty
    a_pwr_out: assert property (p_pwr_out) else $error("power flag wrong");

    property p_drive_en;
        @(posedge ref_clk) disable iff (!nrst)
        out_drive_en == chan_powered;
    endproperty
    a_drive_en: assert property (p_drive_en) else $error("drive enable wrong");

    property p_byp_out;
        @(posedge ref_clk) disable iff (!nrst)
        1'b1
        |=> buffer_bypass[3] == $past(ch_ctrl[3][`DACCI_BIT_BYPASS]);
    endproperty
    a_byp_out: assert property (p_byp_out) else $error("bypass output wrong");

    property p_clr_conv;
        @(posedge ref_clk) disable iff (!nrst)
        !ch_ctrl[2][`DACCI_BIT_CLR_N]
        |=> conv_code[2*`DACCI_CODE_W +: `DACCI_CODE_W] == `DACCI_CODE_RESET;
    endproperty
    a_clr_conv: assert property (p_clr_conv) else $error("cleared code driven");

    property p_clr_hold;
        @(posedge ref_clk) disable iff (!nrst)
        !ch_ctrl[3][`DACCI_BIT_CLR_N]
        |-> !ch_pending[3] && ch_applied[3] == `DACCI_CODE_RESET;
    endproperty
    a_clr_hold: assert property (p_clr_hold) else $error("clear left state");

    property p_core_pend;
        @(posedge ref_clk) disable iff (!nrst)
        (ch_pending[1] && !ch_ctrl[1][`DACCI_BIT_SRC] && !code_we[1])
        |=> !ch_pending[1];
    endproperty
    a_core_pend: assert property (p_core_pend) else $error("core update pending");

    property p_tmr_apply;
        @(posedge ref_clk) disable iff (!nrst)
        (ch_pending[0] && ch_ctrl[0][`DACCI_BIT_SRC] && first_general_timer && !code_we[0]
         && !ctrl_we[0])
        |=> ch_applied[0] == $past(ch_code[0]);
    endproperty
    a_tmr_apply: assert property (p_tmr_apply) else $error("tick did not apply");

    property p_wr_hold;
        @(posedge ref_clk) disable iff (!nrst)
        (code_we[3] && ch_ctrl[3][`DACCI_BIT_CLR_N])
        |=> ch_pending[3] && $stable(ch_applied[3]);
    endproperty
    a_wr_hold: assert property (p_wr_hold) else $error("write applied early");

    property p_wr_code;
        @(posedge ref_clk) disable iff (!nrst)
        (code_we[2] && ch_ctrl[2][`DACCI_BIT_CLR_N])
        |=> ch_code[2] == $past(wdata[`DACCI_CODE_HI:`DACCI_CODE_LO]);
    endproperty
    a_wr_code: assert property (p_wr_code) else $error("code not stored");

    property p_no_strobe;
        @(posedge ref_clk) disable iff (!nrst)
        !wr |-> (ctrl_we == '0) && (code_we == '0);
    endproperty
    a_no_strobe: assert property (p_no_strobe) else $error("write without strobe");

    property p_one_write;
        @(posedge ref_clk) disable iff (!nrst)
        $onehot0({ctrl_we, code_we});
    endproperty
    a_one_write: assert property (p_one_write) else $error("two registers written");

    property p_indep_cd;
        @(posedge ref_clk) disable iff (!nrst)
        code_we[0]
        |=> $stable(ch_code[1]);
    endproperty
    a_indep_cd: assert property (p_indep_cd) else $error("code not independent");

    property p_ctrl_keep;
        @(posedge ref_clk) disable iff (!nrst)
        !ctrl_we[2]
        |=> $stable(ch_ctrl[2]);
    endproperty
    a_ctrl_keep: assert property (p_ctrl_keep) else $error("control changed alone");

    property p_tmr_idle;
        @(posedge ref_clk) disable iff (!nrst)
        (ch_ctrl[3][`DACCI_BIT_SRC] && !first_general_timer && !code_we[3] && !ctrl_we[3])
        |=> $stable(ch_applied[3]);
    endproperty
    a_tmr_idle: assert property (p_tmr_idle) else $error("applied while idle");

    property p_conv3;
        @(posedge ref_clk) disable iff (!nrst)
        1'b1
        |=> conv_code[3*`DACCI_CODE_W +: `DACCI_CODE_W] == $past(ch_applied[3]);
    endproperty
    a_conv3: assert property (p_conv3) else $error("converter code wrong");

    c_timer: cover property (@(posedge ref_clk) ch_pending[0] && first_general_timer);
    c_clear: cover property (@(posedge ref_clk) ctrl_we[1] && !wdata[`DACCI_BIT_CLR_N]);
    c_read: cover property (@(posedge ref_clk) rd ##1 rdata != 32'h0000_0000);
    c_range_ext: cover property (@(posedge ref_clk) chan_powered[0] && range_sel[1:0] == 2'h1);
    c_bypass: cover property (@(posedge ref_clk) buffer_bypass[0] && out_drive_en[0]);
endmodule : dacci_top

// file: tb/dacci_top_tb_top.sv
`timescale 1ns/10ps
`include "dacci_defines.svh"

module dacci_top_tb_top;
    logic        ref_clk;
    logic        nrst;
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
    logic [31:0] rdata;
    logic        first_general_timer;
    logic [47:0] conv_code;
    logic [3:0]  buffer_bypass;
    logic [3:0]  chan_powered;
    logic [3:0]  out_drive_en;
    logic [7:0]  range_sel;
    logic [31:0] rv;
    logic [11:0] held;
    int          n_fail;
    int          check_count;

    dacci_top uut
    (
        .ref_clk             (ref_clk),
        .nrst                (nrst),
        .addr                (addr),
        .wdata               (wdata),
        .wr                  (wr),
        .rd                  (rd),
        .rdata               (rdata),
        .first_general_timer (first_general_timer),
        .conv_code           (conv_code),
        .buffer_bypass       (buffer_bypass),
        .chan_powered        (chan_powered),
        .out_drive_en        (out_drive_en),
        .range_sel           (range_sel)
    );

    initial ref_clk = 1'b0;
    always #12.5 ref_clk = ~ref_clk;

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // One idle edge between accesses keeps every strobe a clean single pulse
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge ref_clk);
        wr    <= 1'b0;
    endtask : wr_reg

    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        rd   <= 1'b1;
        addr <= a;
        @(posedge ref_clk);
        rd   <= 1'b0;
        #1 d = rdata;
    endtask : rd_reg

    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : step

    task automatic report_and_stop;
        $display("checks=%0d mismatches=%0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : report_and_stop

    initial
    begin
        repeat (20000) @(posedge ref_clk);
        n_fail++;
        report_and_stop();
    end

    initial
    begin
        nrst = 1'b0; addr = 8'h00; wdata = 32'h0; wr = 1'b0; rd = 1'b0;
        first_general_timer = 1'b0;
        n_fail = 0; check_count = 0;
        repeat (4) @(posedge ref_clk);
        nrst <= 1'b1;
        for (int n = 0; n < 4; n++)
        begin
            rd_reg(8'(8 * n), rv); chk(rv, 32'h0);
            rd_reg(8'(8 * n + 4), rv); chk(rv, 32'h0);
            chk({31'h0, buffer_bypass[n]}, 32'h0);
            chk({31'h0, out_drive_en[n]}, 32'h0);
        end
        for (int n = 0; n < 4; n++)
        begin
            // Every defined control field set; reserved bits stay zero
            wr_reg(8'(8 * n), 32'h0000_0073);
            rd_reg(8'(8 * n), rv); chk(rv, 32'h0000_0073);
            step(2);
            chk({31'h0, buffer_bypass[n]}, 32'h1);
            chk({30'h0, range_sel[2 * n +: 2]}, 32'h3);
            for (int r = 0; r < 4; r++)
            begin
                wr_reg(8'(8 * n), 32'h10 | r);
                step(2);
                chk({30'h0, range_sel[2 * n +: 2]}, 32'(r));
                chk({31'h0, chan_powered[n]}, 32'(r != 0));
                chk({31'h0, out_drive_en[n]}, 32'(r != 0));
                chk({31'h0, buffer_bypass[n]}, 32'h0);
            end
            // Code written while the clear bit is low must be lost
            wr_reg(8'(8 * n), 32'h0000_0003);
            wr_reg(8'(8 * n + 4), 32'h0055_5000);
            rd_reg(8'(8 * n + 4), rv); chk(rv, 32'h0);
            step(3);
            chk({20'h0, conv_code[12 * n +: 12]}, 32'h0);
            held = 12'habc + 12'(n);
            wr_reg(8'(8 * n), 32'h0000_0013);
            wr_reg(8'(8 * n + 4), {8'h00, held, 12'hfff});
            rd_reg(8'(8 * n + 4), rv); chk(rv, {8'h00, held, 12'h000});
            step(3);
            chk({20'h0, conv_code[12 * n +: 12]}, {20'h0, held});
            // Timer source: the new code waits for a tick
            wr_reg(8'(8 * n), 32'h0000_0033);
            wr_reg(8'(8 * n + 4), 32'h0012_3000);
            step(6);
            chk({20'h0, conv_code[12 * n +: 12]}, {20'h0, held});
            @(posedge ref_clk);
            first_general_timer <= 1'b1;
            @(posedge ref_clk);
            first_general_timer <= 1'b0;
            step(3);
            chk({20'h0, conv_code[12 * n +: 12]}, 32'h123);
            wr_reg(8'(8 * n), 32'h0000_0003);
            step(3);
            chk({20'h0, conv_code[12 * n +: 12]}, 32'h0);
            rd_reg(8'(8 * n + 4), rv); chk(rv, 32'h0);
            chk({30'h0, range_sel[2 * n +: 2]}, 32'h3);
        end
        wr_reg(8'h40, 32'hffff_ffff);
        rd_reg(8'h40, rv); chk(rv, 32'h0);
        rd_reg(8'h00, rv); chk(rv, 32'h0000_0003);
        report_and_stop();
    end
endmodule : dacci_top_tb_top
